/* rtl/pcm_config_mirror.sv */
// Our own choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module pcm_config_mirror (
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire pcm_pkg::pcm_apb_req_t apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // eeprom identity load and role strap
    input wire pcm_pkg::pcm_eeprom_load_t eeprom,
    input wire logic target_role,
    // target address decode
    input wire logic tgt_addr_valid,
    input wire logic [31:0] tgt_addr,
    output logic window0_hit,
    // initiator tenure
    input wire logic initiator_active,
    input wire logic grant_withdrawn,
    output logic tenure_expire,
    // burst read command choice
    input wire logic burst_read_req,
    input wire logic [7:0] burst_len,
    output logic [3:0] burst_read_cmd
);
    // identity fields
    logic [23:0] class_q; // device_class_field
    logic [23:0] class_d;
    logic [7:0] rev_q; // silicon_revision_field
    logic [7:0] rev_d;
    logic [6:0] hdr_q; // header_layout_field
    logic [6:0] hdr_d;
    // software fields
    logic [7:0] tmr_q; // bus_tenure_timer_field
    logic [7:0] tmr_d;
    logic [7:0] lsz_q; // line_size_field
    logic [7:0] lsz_d;
    logic [2:0] base_q; // window 0 base address bits
    logic [2:0] base_d;
    // apb answer
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    // burst command
    pcm_pkg::pcm_read_cmd_t cmd_q;
    pcm_pkg::pcm_read_cmd_t cmd_d;
    // decode helpers
    logic setup; // apb setup cycle
    logic wr_en; // write completes this edge
    logic hit_class;
    logic hit_cfg1;
    logic hit_bar0;
    logic denied; // class register closed to software in target role
    logic [31:0] class_word;
    logic [31:0] cfg1_word;
    logic [31:0] bar0_word;

    // address decode and read words
    always_comb
    begin
        setup = apb.psel && !apb.penable;
        hit_class = apb.paddr == pcm_pkg::PCM_OFF_CLASS;
        hit_cfg1 = apb.paddr == pcm_pkg::PCM_OFF_CFG1;
        hit_bar0 = apb.paddr == pcm_pkg::PCM_OFF_BAR0;
        denied = hit_class && target_role;
        // writes land only in the access cycle that completes
        wr_en = apb.psel && apb.penable && apb.pwrite && pready_q
            && !pslverr_q;
        class_word = 32'h0000_0000;
        class_word[pcm_pkg::PCM_CLASS_LO +: 24] = class_q;
        class_word[pcm_pkg::PCM_REV_LO +: 8] = rev_q;
        // reserved bits 30:24 stay zero
        cfg1_word = 32'h0000_0000;
        cfg1_word[pcm_pkg::PCM_BIST_POS] = pcm_pkg::PCM_BIST_VAL;
        cfg1_word[pcm_pkg::PCM_MFUN_POS] = pcm_pkg::PCM_MFUN_VAL;
        cfg1_word[pcm_pkg::PCM_HDR_LO +: 7] = hdr_q;
        cfg1_word[pcm_pkg::PCM_TMR_LO +: 8] = tmr_q;
        cfg1_word[pcm_pkg::PCM_LSZ_LO +: 8] = lsz_q;
        // bits 28:4 reserved, zero
        bar0_word = 32'h0000_0000;
        bar0_word[pcm_pkg::PCM_BASE_LO +: 3] = base_q;
        bar0_word[pcm_pkg::PCM_PREF_POS] = pcm_pkg::PCM_PREF_VAL;
        bar0_word[pcm_pkg::PCM_TYPE_LO +: 2] = pcm_pkg::PCM_TYPE_VAL;
        bar0_word[pcm_pkg::PCM_SPACE_POS] = pcm_pkg::PCM_SPACE_VAL;
    end

    // apb answer: prepared in setup, presented in access
    always_comb
    begin
        pready_d = setup;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (setup)
        begin
            if (denied)
            begin
                pslverr_d = 1'b1;
            end
            else if (hit_class)
            begin
                prdata_d = class_word;
            end
            else if (hit_cfg1)
            begin
                prdata_d = cfg1_word;
            end
            else if (hit_bar0)
            begin
                prdata_d = bar0_word;
            end
            else
            begin
                pslverr_d = 1'b1; // unmapped address
            end
            if (apb.pwrite)
            begin
                prdata_d = 32'h0000_0000;
            end
        end
    end

    // apb answer registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // field updates: software writes, eeprom loads identity
    always_comb
    begin
        class_d = class_q;
        rev_d = rev_q;
        hdr_d = hdr_q;
        tmr_d = tmr_q;
        lsz_d = lsz_q;
        base_d = base_q;
        if (wr_en && hit_cfg1)
        begin
            // identity bits of this word are read-only
            tmr_d = apb.pwdata[pcm_pkg::PCM_TMR_LO +: 8]
                & pcm_pkg::PCM_TMR_MASK;
            lsz_d = apb.pwdata[pcm_pkg::PCM_LSZ_LO +: 8];
        end
        if (wr_en && hit_bar0)
        begin
            base_d = apb.pwdata[pcm_pkg::PCM_BASE_LO +: 3];
        end
        if (eeprom.valid)
        begin
            class_d = eeprom.dev_class;
            rev_d = eeprom.rev;
            hdr_d = eeprom.hdr;
        end
    end

    // field registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            class_q <= pcm_pkg::PCM_CLASS_RST;
            rev_q <= pcm_pkg::PCM_REV_RST;
            hdr_q <= pcm_pkg::PCM_HDR_RST;
            tmr_q <= pcm_pkg::PCM_TMR_RST;
            lsz_q <= pcm_pkg::PCM_LSZ_RST;
            base_q <= pcm_pkg::PCM_BASE_RST;
        end
        else
        begin
            class_q <= class_d;
            rev_q <= rev_d;
            hdr_q <= hdr_d;
            tmr_q <= tmr_d;
            lsz_q <= lsz_d;
            base_q <= base_d;
        end
    end

    // burst read command from the line size
    always_comb
    begin
        cmd_d = cmd_q;
        if (burst_read_req)
        begin
            if (lsz_q == 8'h00)
            begin
                cmd_d = pcm_pkg::PCM_CMD_MEM_READ; // line size unset
            end
            else if (burst_len > lsz_q)
            begin
                cmd_d = pcm_pkg::PCM_CMD_READ_MULTI;
            end
            else
            begin
                cmd_d = pcm_pkg::PCM_CMD_READ_LINE;
            end
        end
    end

    // burst command register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmd_q <= pcm_pkg::PCM_CMD_MEM_READ;
        end
        else
        begin
            cmd_q <= cmd_d;
        end
    end

    // target window 0 decode
    pcm_window_decode u_window (
        .clk(clk),
        .rst(rst),
        .base(base_q),
        .addr_valid(tgt_addr_valid),
        .addr(tgt_addr),
        .hit(window0_hit)
    );

    // initiator tenure end after grant loss
    pcm_tenure_timer u_tenure (
        .clk(clk),
        .rst(rst),
        .active(initiator_active),
        .withdrawn(grant_withdrawn),
        .limit(tmr_q),
        .expire(tenure_expire)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign burst_read_cmd = cmd_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // denied class access errors with zero data
    a_class_denied_err: assert property (
        (setup && hit_class && target_role) |=> pready_q && pslverr_q
        && prdata_q == 32'h0000_0000)
        else $error("class register not denied in target role");
    // software cannot change the class word
    a_class_read_only: assert property (
        (wr_en && hit_class && !eeprom.valid) |=> $stable(class_q)
        && $stable(rev_q))
        else $error("class register changed by software write");
    // eeprom load replaces identity fields
    a_eeprom_class_load: assert property (
        eeprom.valid |=> class_q == $past(eeprom.dev_class)
        && hdr_q == $past(eeprom.hdr))
        else $error("eeprom class or header load lost");
    a_eeprom_rev_load: assert property (
        eeprom.valid |=> rev_q == $past(eeprom.rev))
        else $error("eeprom revision load lost");
    // fixed identity bits read zero
    a_bist_bit_zero: assert property (
        (setup && hit_cfg1 && !apb.pwrite) |=> !prdata_q[31])
        else $error("self-test bit read as one");
    a_mfunc_bit_zero: assert property (
        (setup && hit_cfg1 && !apb.pwrite) |=> !prdata_q[23])
        else $error("multi-function bit read as one");
    // header type readable and software-proof
    a_header_read: assert property (
        (setup && hit_cfg1 && !apb.pwrite) |=> prdata_q[22:16]
        == $past(hdr_q))
        else $error("header type read wrong");
    // timer write keeps upper six bits, clears low two
    a_timer_write: assert property (
        (wr_en && hit_cfg1 && !eeprom.valid) |=> tmr_q
        == {$past(apb.pwdata[15:10]), 2'b00} && $stable(hdr_q))
        else $error("timer write not masked to multiple of four");
    a_line_size_write: assert property (
        (wr_en && hit_cfg1) |=> lsz_q == $past(apb.pwdata[7:0]))
        else $error("line size write lost");
    // window 0 base fixed low bits
    a_bar_low_bits: assert property (
        (setup && hit_bar0 && !apb.pwrite) |=> prdata_q[28:0]
        == 29'h0000_0008)
        else $error("window base low bits not 1000 with zero reserve");
    // reserved bits of the config word read zero
    a_cfg1_reserved: assert property (
        (setup && hit_cfg1 && !apb.pwrite) |=> prdata_q[30:24] == 7'h00)
        else $error("reserved config bits not zero");

    // class word reads back the identity fields
    a_class_word_read: assert property (
        (setup && hit_class && !target_role && !apb.pwrite) |=> prdata_q
        == {$past(class_q), $past(rev_q)})
        else $error("class word read does not show identity fields");
    // timer field reads back and keeps its low bits clear
    a_timer_read: assert property (
        (setup && hit_cfg1 && !apb.pwrite) |=> prdata_q[15:8]
        == $past(tmr_q))
        else $error("timer field read wrong");
    a_timer_low_zero: assert property (
        tmr_q[1:0] == 2'b00)
        else $error("timer low bits not zero");
    // software sets the window base
    a_base_write: assert property (
        (wr_en && hit_bar0) |=> base_q == $past(apb.pwdata[31:29]))
        else $error("window base write lost");
    // window type and space bits read zero
    a_bar_type_bits: assert property (
        (setup && hit_bar0 && !apb.pwrite) |=> prdata_q[2:1] == 2'b00)
        else $error("window type bits not zero");
    a_bar_space_bit: assert property (
        (setup && hit_bar0 && !apb.pwrite) |=> !prdata_q[0])
        else $error("window space bit not zero");
    // burst command follows the line size
    a_burst_no_line: assert property (
        (burst_read_req && lsz_q == 8'h00) |=> cmd_q
        == pcm_pkg::PCM_CMD_MEM_READ)
        else $error("unset line size did not pick memory read");
    a_burst_multi: assert property (
        (burst_read_req && lsz_q != 8'h00 && burst_len > lsz_q) |=>
        cmd_q == pcm_pkg::PCM_CMD_READ_MULTI)
        else $error("long burst did not pick read multiple");
    a_burst_line: assert property (
        (burst_read_req && lsz_q != 8'h00 && burst_len <= lsz_q) |=>
        cmd_q == pcm_pkg::PCM_CMD_READ_LINE)
        else $error("short burst did not pick read line");
    // end request holds until the initiator lets go
    a_expire_hold: assert property (
        (tenure_expire && initiator_active) |=> tenure_expire)
        else $error("end request dropped while access active");
endmodule : pcm_config_mirror
`default_nettype wire

/* rtl/pcm_pkg.sv */
// Functional notes
// - class/revision register denied in add-in target role
// - class code bits 31:8, reset 0x060000, read-only
// - eeprom load may replace class code
// - revision bits 7:0 read-only, eeprom-loadable
// - self-test capable bit 31 reads zero
// - multi-function bit 23 reads zero
// - header type 22:16 resets zero, eeprom-loadable
// - grant withdrawn: end access after timer clocks
// - timer low two bits forced zero
// - timer resets zero, software read/write
// - line size read/write, picks burst read command
// - window 0 base bits 31:29 decode hits
// - window 0 bit 3 reads one, prefetchable
// - window 0 bits 2:1 read zero, 32-bit
// - window 0 bit 0 reads zero, memory space
package pcm_pkg;
    // register byte addresses
    localparam logic [31:0] PCM_OFF_CLASS = 32'h0000_d008;
    localparam logic [31:0] PCM_OFF_CFG1 = 32'h0000_d00c;
    localparam logic [31:0] PCM_OFF_BAR0 = 32'h0000_d010;
    // reset values
    localparam logic [23:0] PCM_CLASS_RST = 24'h06_0000;
    localparam logic [7:0] PCM_REV_RST = 8'h01; // arbitrary value
    localparam logic [6:0] PCM_HDR_RST = 7'h00;
    localparam logic [7:0] PCM_TMR_RST = 8'h00;
    localparam logic [7:0] PCM_LSZ_RST = 8'h00;
    localparam logic [2:0] PCM_BASE_RST = 3'h0;
    // field positions and widths
    localparam int PCM_CLASS_LO = 8;
    localparam int PCM_REV_LO = 0;
    localparam int PCM_BIST_POS = 31;
    localparam int PCM_MFUN_POS = 23;
    localparam int PCM_HDR_LO = 16;
    localparam int PCM_TMR_LO = 8;
    localparam int PCM_LSZ_LO = 0;
    localparam int PCM_BASE_LO = 29;
    localparam int PCM_PREF_POS = 3;
    localparam int PCM_TYPE_LO = 1;
    localparam int PCM_SPACE_POS = 0;
    // fixed field values
    localparam logic PCM_BIST_VAL = 1'b0;
    localparam logic PCM_MFUN_VAL = 1'b0;
    localparam logic PCM_PREF_VAL = 1'b1;
    localparam logic [1:0] PCM_TYPE_VAL = 2'h0;
    localparam logic PCM_SPACE_VAL = 1'b0;
    // timer count granularity: low two bits held at zero
    localparam logic [7:0] PCM_TMR_MASK = 8'hfc;
    // pci read commands chosen by line size
    typedef enum logic [3:0] {
        PCM_CMD_MEM_READ = 4'h6,
        PCM_CMD_READ_MULTI = 4'hc,
        PCM_CMD_READ_LINE = 4'he
    } pcm_read_cmd_t;
    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } pcm_apb_req_t;
    // identity words from the eeprom loader
    typedef struct packed {
        logic valid;
        logic [23:0] dev_class;
        logic [7:0] rev;
        logic [6:0] hdr;
    } pcm_eeprom_load_t;
endpackage : pcm_pkg

/* rtl/pcm_tenure_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module pcm_tenure_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic active,
    input wire logic withdrawn,
    input wire logic [7:0] limit,
    output logic expire
);
    logic run_q; // grant has been withdrawn in this access
    logic run_d;
    logic [7:0] cnt_q; // clocks since grant loss
    logic [7:0] cnt_d;
    logic exp_q; // end request, held until access ends
    logic exp_d;

    // count bus clocks after grant loss, stop at the limit
    always_comb
    begin
        run_d = 1'b0;
        cnt_d = 8'h00;
        exp_d = 1'b0;
        if (active && (withdrawn || run_q))
        begin
            run_d = 1'b1;
            if (exp_q || cnt_q >= limit)
            begin
                exp_d = 1'b1;
                cnt_d = cnt_q;
            end
            else
            begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    // timer state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            run_q <= 1'b0;
            cnt_q <= 8'h00;
            exp_q <= 1'b0;
        end
        else
        begin
            run_q <= run_d;
            cnt_q <= cnt_d;
            exp_q <= exp_d;
        end
    end

    assign expire = exp_q;

    a_tenure_zero_end: assert property (
        @(posedge clk) disable iff (rst)
        (active && withdrawn && limit == 8'h00) |=> exp_q)
        else $error("zero limit did not end access at once");
    a_tenure_not_early: assert property (
        @(posedge clk) disable iff (rst)
        (exp_q && !$past(exp_q)) |-> $past(cnt_q) >= $past(limit))
        else $error("access ended before limit reached");
endmodule : pcm_tenure_timer
`default_nettype wire

/* rtl/pcm_window_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module pcm_window_decode (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] base,
    input wire logic addr_valid,
    input wire logic [31:0] addr,
    output logic hit
);
    logic hit_q; // registered hit flag
    logic hit_d;

    // 512 MB window: only the top three address bits decide
    always_comb
    begin
        hit_d = addr_valid && (addr[pcm_pkg::PCM_BASE_LO +: 3] == base);
    end

    // hold the decode result
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hit_q <= 1'b0;
        end
        else
        begin
            hit_q <= hit_d;
        end
    end

    assign hit = hit_q;

    a_window_hit_match: assert property (
        @(posedge clk) disable iff (rst)
        addr_valid |=> hit_q == ($past(addr[31:29]) == $past(base)))
        else $error("window hit does not follow base compare");
endmodule : pcm_window_decode
`default_nettype wire

/* tb/pcm_apb_master.sv */
`timescale 1ns/100ps
`default_nettype none
// apb master standing in for host configuration software
module pcm_apb_master (
    input wire logic clk,
    output pcm_pkg::pcm_apb_req_t apb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic hung
);
    // bus idle at time zero
    initial
    begin
        apb = '0;
        hung = 1'b0;
    end
    // one transfer: setup, then access held until pready at an edge
    task automatic xfer(input logic wr, input logic [31:0] a, d,
        output logic [31:0] rdata, output logic err);
        int n;
        n = 0;
        apb.psel <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite <= wr;
        apb.paddr <= a;
        apb.pwdata <= d;
        @(posedge clk);
        apb.penable <= 1'b1;
        // bounded wait for the answer
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        hung = (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
    endtask : xfer
    // release the bus; stale write data is inverted, not left standing
    task automatic idle();
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
        apb.pwdata <= ~apb.pwdata;
        @(posedge clk);
    endtask : idle
endmodule : pcm_apb_master
`default_nettype wire

/* tb/pcm_config_mirror_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the configuration mirror
module pcm_config_mirror_tb;
    logic clk, rst; // 200 MHz clock, async active-high reset
    pcm_pkg::pcm_apb_req_t apb; // request from the master model
    pcm_pkg::pcm_eeprom_load_t eeprom; // identity load
    logic [31:0] prdata, tgt_addr, r, a;
    logic pready, pslverr, target_role, tgt_addr_valid, window0_hit;
    logic initiator_active, grant_withdrawn, tenure_expire;
    logic burst_read_req;
    logic [7:0] burst_len, len;
    logic [3:0] burst_read_cmd;
    logic [23:0] dc; // expected class code
    logic [7:0] rv, tm, ls; // expected revision, timer, line size
    logic [6:0] hd; // expected header type
    logic [2:0] ba; // expected window base
    int fail_count, tests_run;
    localparam logic [31:0] ID_A = pcm_pkg::PCM_OFF_CLASS;
    localparam logic [31:0] CFG_A = pcm_pkg::PCM_OFF_CFG1;
    localparam logic [31:0] BAR_A = pcm_pkg::PCM_OFF_BAR0;

    pcm_config_mirror dut (.clk(clk), .rst(rst), .apb(apb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eeprom(eeprom), .target_role(target_role),
        .tgt_addr_valid(tgt_addr_valid), .tgt_addr(tgt_addr),
        .window0_hit(window0_hit), .initiator_active(initiator_active),
        .grant_withdrawn(grant_withdrawn), .tenure_expire(tenure_expire),
        .burst_read_req(burst_read_req), .burst_len(burst_len),
        .burst_read_cmd(burst_read_cmd));
    pcm_apb_master u_mst (.clk(clk), .apb(apb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hung());

    // free-running clock, 5 ns period
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    // compare one value and count it
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one apb transfer; error flag compared, read data on reads only
    task automatic bus(input logic wr, input logic [31:0] ad, d,
        input logic [31:0] exp, input logic exp_err);
        logic [31:0] got;
        logic e;
        u_mst.xfer(wr, ad, d, got, e);
        // read the flag where it is set, not through the port copy
        if (u_mst.hung)
        begin
            fail_count++;
            results();
        end
        check("pslverr", {31'h0, exp_err}, {31'h0, e});
        if (!wr)
            check("prdata", exp, got);
    endtask : bus
    // expected register words
    function automatic logic [31:0] cfg1_word();
        return {1'b0, 7'h00, 1'b0, hd, tm, ls};
    endfunction : cfg1_word
    function automatic logic [31:0] bar_word();
        return {ba, 25'h000_0000, 4'h8};
    endfunction : bar_word
    // expected burst read command for a length
    function automatic logic [3:0] exp_cmd(input logic [7:0] n);
        if (ls == 8'h00)
            return 4'h6;
        return (n > ls) ? 4'hc : 4'he;
    endfunction : exp_cmd
    // rewrite line size and timer together
    task automatic set_cfg1();
        bus(1'b1, CFG_A, {16'h0000, tm, ls}, '0, 1'b0);
        u_mst.idle();
    endtask : set_cfg1

    // main sequence
    initial
    begin
        fail_count = 0;
        tests_run = 0;
        rst = 1'b1;
        eeprom = '0;
        target_role = 1'b0;
        tgt_addr_valid = 1'b0;
        tgt_addr = '0;
        initiator_active = 1'b0;
        grant_withdrawn = 1'b0;
        burst_read_req = 1'b0;
        burst_len = '0;
        dc = 24'h06_0000;
        rv = pcm_pkg::PCM_REV_RST;
        {hd, tm, ls, ba} = '0;
        void'($urandom(32'h811e));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values, back to back
        bus(1'b0, ID_A, '0, {dc, rv}, 1'b0);
        bus(1'b0, CFG_A, '0, cfg1_word(), 1'b0);
        bus(1'b0, BAR_A, '0, bar_word(), 1'b0);
        // random writes, all ones first; read-only bits stay put
        for (int i = 0; i < 8; i++)
        begin
            r = (i == 0) ? 32'hffff_ffff : $urandom;
            bus(1'b1, CFG_A, r, '0, 1'b0);
            tm = r[15:8] & 8'hfc;
            ls = r[7:0];
            bus(1'b0, CFG_A, '0, cfg1_word(), 1'b0);
            bus(1'b1, BAR_A, ~r, '0, 1'b0);
            ba = ~r[31:29];
            bus(1'b0, BAR_A, '0, bar_word(), 1'b0);
            bus(1'b1, ID_A, r, '0, 1'b0);
            bus(1'b0, ID_A, '0, {dc, rv}, 1'b0);
        end
        // unmapped word answers an error with zero data
        bus(1'b0, BAR_A + 32'h0000_0004, '0, '0, 1'b1);
        u_mst.idle();
        // add-in target role closes the class register
        target_role <= 1'b1;
        bus(1'b0, ID_A, '0, '0, 1'b1);
        bus(1'b1, ID_A, '0, '0, 1'b1);
        u_mst.idle();
        target_role <= 1'b0;
        // identity load replaces class, revision and header type
        r = $urandom;
        a = $urandom;
        eeprom <= {1'b1, r[23:0], a[7:0], a[14:8]};
        @(posedge clk);
        eeprom.valid <= 1'b0;
        {dc, rv, hd} = {r[23:0], a[7:0], a[14:8]};
        bus(1'b0, ID_A, '0, {dc, rv}, 1'b0);
        bus(1'b0, CFG_A, '0, cfg1_word(), 1'b0);
        u_mst.idle();
        // window decode: both edges of the window, then random
        for (int i = 0; i < 12; i++)
        begin
            r = $urandom;
            a = (i == 0) ? {ba, 29'h0000_0000} :
                (i == 1) ? {ba, 29'h1fff_ffff} :
                (i == 2) ? {ba + 3'h1, 29'h0000_0000} : r;
            tgt_addr_valid <= (i != 11);
            tgt_addr <= a;
            @(posedge clk);
            @(posedge clk);
            check("window0_hit", {31'h0, (i != 11) && a[31:29] == ba},
                {31'h0, window0_hit});
        end
        tgt_addr_valid <= 1'b0;
        // tenure: expiry exactly the programmed count after withdrawal
        for (int k = 0; k < 3; k++)
        begin
            tm = (k == 0) ? 8'h00 : 8'($urandom & 32'h0000_001c);
            set_cfg1();
            initiator_active <= 1'b1;
            grant_withdrawn <= 1'b1;
            // withdrawal taken at the next edge; end request rises tm
            // edges after it, so it is first seen one edge later still
            repeat (int'(tm) + 1) @(posedge clk);
            check("expire early", '0, {31'h0, tenure_expire});
            @(posedge clk);
            check("expire", 32'h0000_0001, {31'h0, tenure_expire});
            initiator_active <= 1'b0;
            grant_withdrawn <= 1'b0;
            repeat (2) @(posedge clk);
        end
        // burst read command over line size and length boundaries
        for (int k = 0; k < 3; k++)
        begin
            ls = (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : $urandom;
            set_cfg1();
            for (int j = 0; j < 4; j++)
            begin
                len = (j == 0) ? ls : (j == 1) ? ls + 8'h01 :
                    (j == 2) ? 8'h00 : 8'hff;
                burst_read_req <= 1'b1;
                burst_len <= len;
                @(posedge clk);
                burst_read_req <= 1'b0;
                @(posedge clk);
                check("burst_read_cmd", {28'h0, exp_cmd(len)},
                    {28'h0, burst_read_cmd});
            end
        end
        results();
    end
endmodule : pcm_config_mirror_tb
`default_nettype wire
